// ### core/pvsc_ctrl.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
// Overview of operation
// - Two-bit code divides reference clock by 2, 4, 8 or 16; default 16.
// - Calibration starts only when the active request bit rises from 0 to 1.
// - Sync mode bits 7:6: 00/11 none, 01 async reset, 10 sync reset.
// - Reference path delay field bits 5:3, reset zero.
// - Feedback path delay field, reset zero, same code mapping.
// - Status divide enable passes the status signal through divide by 4.
module pvsc_ctrl (
  input  wire logic        mclk,             // 40 MHz system clock
  input  wire logic        sys_rst,          // Synchronous reset, active high
  input  wire logic [11:0] avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Wait request
  input  wire logic        ref_tick,         // One pulse per reference clock period
  input  wire logic        sync_pin,         // External sync, active high
  input  wire logic        status_src,       // Signal routed to status pin
  output logic             status_pin,       // Status pin output
  output logic             counter_rst,      // Reset to reference and feedback counters
  output logic      [2:0]  ref_delay,        // Active reference path delay code
  output logic      [2:0]  fb_delay,         // Active feedback path delay code
  output logic             cal_busy          // Calibration in progress
);

  pvsc_pkg::pvsc_avm_req_t req;
  pvsc_pkg::pvsc_regs_t    shadow_r, shadow_nxt;
  pvsc_pkg::pvsc_regs_t    active_r, active_nxt;
  pvsc_pkg::pvsc_cal_state_t cal_st_r, cal_st_nxt;
  logic [7:0]  cal_cnt_r, cal_cnt_nxt;
  logic [3:0]  div_cnt_r, div_cnt_nxt;
  logic [3:0]  div_mask;
  logic        cal_tick;
  logic        cal_prev_r, cal_prev_nxt;
  logic        ack_r, ack_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        crst_r, crst_nxt;
  logic [1:0]  sdiv_r, sdiv_nxt;
  logic        ssrc_prev_r, ssrc_prev_nxt;
  logic        busy_r, busy_nxt;
  logic        spin_r, spin_nxt;
  logic        update;
  logic [9:0]  idx;
  pvsc_pkg::pvsc_sync_mode_t smode;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  assign idx = req.address[11:2];

  // Bus: one wait cycle, then the access completes on the edge where waitrequest is low
  always_comb begin
    ack_nxt    = (req.read | req.write) & ~ack_r;
    wait_nxt   = ~ack_nxt;
    rdata_nxt  = rdata_r;
    shadow_nxt = shadow_r;
    update     = 1'b0;
    // Read data latched on the request cycle, so it stands while waitrequest is low
    if (req.read && !ack_r) begin
      case (idx)
        pvsc_pkg::IDX_CAL_CTRL:   rdata_nxt = {24'h000000, shadow_r.cal_ctrl};
        pvsc_pkg::IDX_SYNC_DELAY: rdata_nxt = {24'h000000, shadow_r.sync_delay};
        pvsc_pkg::IDX_STAT_DIV:   rdata_nxt = {24'h000000, shadow_r.stat_div};
        pvsc_pkg::IDX_STATUS:     rdata_nxt = {31'h00000000, cal_busy};
        default:                  rdata_nxt = 32'h00000000;
      endcase
    end
    // Writes land only on the edge where waitrequest is low
    if (req.write && ack_r) begin
      case (idx)
        pvsc_pkg::IDX_CAL_CTRL:   shadow_nxt.cal_ctrl   = req.writedata[7:0];
        pvsc_pkg::IDX_SYNC_DELAY: shadow_nxt.sync_delay = req.writedata[7:0];
        pvsc_pkg::IDX_STAT_DIV:   shadow_nxt.stat_div   = req.writedata[7:0];
        pvsc_pkg::IDX_UPDATE:     update = req.writedata[pvsc_pkg::UPDATE_BIT];
        // Status is read-only; writes to it fall here and are dropped
        default:                  update = 1'b0;
      endcase
    end
  end

  // Shadow values reach the logic only on the update strobe
  // Reads show the shadow copy, so software can stage a full set first
  always_comb begin
    active_nxt = update ? shadow_r : active_r;
  end

  // Calibration clock divider and sequencer
  always_comb begin
    // Low divider bits that must all be set for a calibration tick
    div_mask     = 4'hF >> (2'd3 - active_r.cal_ctrl[pvsc_pkg::CAL_DIV_MSB:
                                                   pvsc_pkg::CAL_DIV_LSB]);
    cal_tick     = ref_tick && ((div_cnt_r & div_mask) == div_mask);
    // Free-running divider: a run's first tick may come up to one period early
    div_cnt_nxt  = ref_tick ? div_cnt_r + 4'h1 : div_cnt_r;
    // Previous request level for the rise detector
    cal_prev_nxt = active_r.cal_ctrl[pvsc_pkg::CAL_NOW_BIT];
    cal_st_nxt   = cal_st_r;
    cal_cnt_nxt  = cal_cnt_r;
    case (cal_st_r)
      pvsc_pkg::PVSC_CAL_IDLE: begin
        // Level of the request bit is ignored; only its rise starts a run
        if (active_r.cal_ctrl[pvsc_pkg::CAL_NOW_BIT] && !cal_prev_r) begin
          cal_st_nxt  = pvsc_pkg::PVSC_CAL_RUN;
          cal_cnt_nxt = pvsc_pkg::CAL_TICKS;
        end
      end
      pvsc_pkg::PVSC_CAL_RUN: begin
        // Rises during a run are lost; a new run needs a fresh 0 then 1
        if (cal_tick) begin
          cal_cnt_nxt = cal_cnt_r - 8'h01;
          if (cal_cnt_r == 8'h01) begin
            cal_st_nxt = pvsc_pkg::PVSC_CAL_IDLE;
          end
        end
      end
      default: cal_st_nxt = pvsc_pkg::PVSC_CAL_IDLE;
    endcase
    // Busy taken from the next state so the output flop tracks the state
    busy_nxt = (cal_st_nxt == pvsc_pkg::PVSC_CAL_RUN);
  end

  // Counter reset from sync pin
  always_comb begin
    smode = pvsc_pkg::pvsc_sync_mode_t'(active_r.sync_delay[pvsc_pkg::SYNC_MODE_MSB:
                                                            pvsc_pkg::SYNC_MODE_LSB]);
    case (smode)
      // Async mode still passes one flop, since every output is registered
      pvsc_pkg::PVSC_SYNC_ASYNC: crst_nxt = sync_pin;
      // Synchronous mode only changes the reset on a reference edge
      pvsc_pkg::PVSC_SYNC_SYNC:  crst_nxt = ref_tick ? sync_pin : crst_r;
      pvsc_pkg::PVSC_SYNC_NONE:  crst_nxt = 1'b0;
      default:                   crst_nxt = 1'b0;
    endcase
  end

  // Status pin with optional divide by 4 on rising edges
  always_comb begin
    // Edge detector resets low, the idle level of the source, so no false edge
    ssrc_prev_nxt = status_src;
    sdiv_nxt = (status_src && !ssrc_prev_r) ? sdiv_r + 2'b01 : sdiv_r;
    spin_nxt = active_r.stat_div[pvsc_pkg::STAT_DIV_BIT] ? sdiv_r[1] : status_src;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_r    <= 1'b0;
      wait_r   <= 1'b1;
      rdata_r  <= 32'h00000000;
      shadow_r <= '{cal_ctrl: pvsc_pkg::CAL_CTRL_RST,
                    sync_delay: pvsc_pkg::SYNC_DELAY_RST,
                    stat_div: pvsc_pkg::STAT_DIV_RST};
    end else begin
      ack_r    <= ack_nxt;
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
      shadow_r <= shadow_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active_r <= '{cal_ctrl: pvsc_pkg::CAL_CTRL_RST,
                    sync_delay: pvsc_pkg::SYNC_DELAY_RST,
                    stat_div: pvsc_pkg::STAT_DIV_RST};
    end else begin
      active_r <= active_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_st_r   <= pvsc_pkg::PVSC_CAL_IDLE;
      cal_cnt_r  <= 8'h00;
      div_cnt_r  <= 4'h0;
      cal_prev_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      cal_st_r   <= cal_st_nxt;
      cal_cnt_r  <= cal_cnt_nxt;
      div_cnt_r  <= div_cnt_nxt;
      cal_prev_r <= cal_prev_nxt;
      busy_r     <= busy_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      crst_r <= 1'b0;
    end else begin
      crst_r <= crst_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdiv_r      <= 2'b00;
      ssrc_prev_r <= 1'b0;
      spin_r      <= 1'b0;
    end else begin
      sdiv_r      <= sdiv_nxt;
      ssrc_prev_r <= ssrc_prev_nxt;
      spin_r      <= spin_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign status_pin      = spin_r;
  assign counter_rst     = crst_r;
  // Codes leave raw; the code-to-delay table lives in the delay cells
  assign ref_delay       = active_r.sync_delay[pvsc_pkg::REF_DLY_MSB:
                                               pvsc_pkg::REF_DLY_LSB];
  assign fb_delay        = active_r.sync_delay[pvsc_pkg::FB_DLY_MSB:
                                               pvsc_pkg::FB_DLY_LSB];
  assign cal_busy        = busy_r;

endmodule

// ### core/pvsc_pkg.sv
package pvsc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CAL_CTRL   = 10'h018;
  localparam logic [9:0] IDX_SYNC_DELAY = 10'h019;
  localparam logic [9:0] IDX_STAT_DIV   = 10'h01A;
  localparam logic [9:0] IDX_STATUS     = 10'h01F;
  localparam logic [9:0] IDX_UPDATE     = 10'h232;

  localparam int ADDR_W = 12;

  // Calibration control fields
  localparam int CAL_NOW_BIT = 0;
  localparam int CAL_DIV_LSB = 1;
  localparam int CAL_DIV_MSB = 2;
  localparam logic [7:0] CAL_CTRL_RST = 8'h06;

  // Counter sync and path delay fields
  localparam int SYNC_MODE_LSB = 6;
  localparam int SYNC_MODE_MSB = 7;
  localparam int REF_DLY_LSB   = 3;
  localparam int REF_DLY_MSB   = 5;
  localparam int FB_DLY_LSB    = 0;
  localparam int FB_DLY_MSB    = 2;
  localparam logic [7:0] SYNC_DELAY_RST = 8'h00;

  localparam int STAT_DIV_BIT = 7;
  localparam logic [7:0] STAT_DIV_RST = 8'h00;

  localparam int UPDATE_BIT    = 0;
  localparam int STATUS_BUSY   = 0;

  // Calibration length in calibration-clock ticks
  localparam logic [7:0] CAL_TICKS = 8'h20;

  typedef enum logic [1:0] {
    PVSC_SYNC_NONE  = 2'b00,
    PVSC_SYNC_ASYNC = 2'b01,
    PVSC_SYNC_SYNC  = 2'b10,
    PVSC_SYNC_NONE2 = 2'b11
  } pvsc_sync_mode_t;

  typedef enum logic [0:0] {
    PVSC_CAL_IDLE = 1'b0,
    PVSC_CAL_RUN  = 1'b1
  } pvsc_cal_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
  } pvsc_avm_req_t;

  typedef struct packed {
    logic [7:0] cal_ctrl;
    logic [7:0] sync_delay;
    logic [7:0] stat_div;
  } pvsc_regs_t;

endpackage

// ### sim/pvsc_ctrl_checker.sv
`timescale 1ns/10ps
module pvsc_ctrl_checker (
  input wire logic        mclk,             // Clock
  input wire logic        sys_rst,          // Reset
  input wire logic [11:0] avs_address,      // Address
  input wire logic        avs_read,         // Read
  input wire logic        avs_write,        // Write
  input wire logic [31:0] avs_writedata,    // Write data
  input wire logic [31:0] avs_readdata,     // Read data
  input wire logic        avs_waitrequest,  // Wait
  input wire logic        sync_pin,         // Sync in
  input wire logic        counter_rst,      // Counter reset
  input wire logic [2:0]  ref_delay,        // Ref delay
  input wire logic [2:0]  fb_delay,         // Fb delay
  input wire logic        cal_busy          // Busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic upd = avs_write && !avs_waitrequest && avs_writedata[0]
    && avs_address[11:2] == pvsc_pkg::IDX_UPDATE;
  sequence s_ask;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (s_ask |=> s_done) else $error("bus answer late");
  a_bus_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("wait low while idle");
  a_read_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_delay_on_commit: assert property (
    $changed({ref_delay, fb_delay}) |-> $past(upd) || $past(upd, 2) || $past(upd, 3))
    else $error("delay moved unasked");
  a_cal_on_commit: assert property ($rose(cal_busy) |->
    $past(upd) || $past(upd, 2) || $past(upd, 3)) else $error("calibration unasked");
  a_cal_min_run: assert property ($rose(cal_busy) |=> cal_busy [*8])
    else $error("calibration too short");
  a_cal_end_late: assert property ($fell(cal_busy) |-> $past(cal_busy, 8))
    else $error("calibration ended early");
  a_rst_needs_sync: assert property ($rose(counter_rst) |-> $past(sync_pin))
    else $error("counter reset without sync");
endmodule
bind pvsc_ctrl pvsc_ctrl_checker pvsc_ctrl_checker_i (.mclk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sync_pin, .counter_rst,
  .ref_delay, .fb_delay, .cal_busy);

// ### sim/pvsc_ctrl_test.sv
`timescale 1ns/10ps
module pvsc_ctrl_test;
  logic        mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, ref_tick = 0, p;
  logic        sync_pin = 0, status_src = 0, avs_waitrequest, status_pin, counter_rst, cal_busy;
  logic [11:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, exp_q[$];
  logic [2:0]  ref_delay, fb_delay;
  logic [1:0]  tcnt = 0;
  logic [7:0]  d;
  int          bad_count = 0, checked = 0, seed = 32'hd83688dd, n, k, e;
  int          busy_len = 0;
  pvsc_ctrl pvsc_ctrl_i (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ref_tick, .sync_pin, .status_src, .status_pin,
    .counter_rst, .ref_delay, .fb_delay, .cal_busy);
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    ref_tick <= tcnt == 2'h3;
    tcnt <= tcnt + 2'h1;
  end
  // Length of the current busy stretch, counted from the rise itself
  always @(posedge mclk) busy_len <= (cal_busy === 1'b1) ? busy_len + 1 : 0;
  task automatic print_verdict;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] wd,
                     input logic [7:0] x);
    int i;
    avs_address <= {a, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= w;
    avs_read <= !w;
    if (!w) exp_q.push_back({24'h0, x});
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++) @(posedge mclk);
    if (i == 20) begin
      bad_count++;
      print_verdict();
    end
    avs_write <= 0;
    avs_read <= 0;
    @(posedge mclk);
  endtask
  task automatic commit;
    acc(1, pvsc_pkg::IDX_UPDATE, 8'h01, 8'h00);
    repeat (3) @(posedge mclk);
  endtask
  always @(posedge mclk) if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    check(avs_readdata, exp_q.pop_front());
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    acc(0, pvsc_pkg::IDX_CAL_CTRL, 0, pvsc_pkg::CAL_CTRL_RST);
    acc(0, pvsc_pkg::IDX_SYNC_DELAY, 0, pvsc_pkg::SYNC_DELAY_RST);
    acc(0, pvsc_pkg::IDX_STAT_DIV, 0, pvsc_pkg::STAT_DIV_RST);
    acc(0, 10'h3FF, 0, 8'h00);
    d = $random(seed);
    acc(1, pvsc_pkg::IDX_SYNC_DELAY, {2'b00, d[5:0]}, 0);
    acc(0, pvsc_pkg::IDX_SYNC_DELAY, 0, {2'b00, d[5:0]});
    check({26'h0, ref_delay, fb_delay}, 32'h0);
    commit();
    check({26'h0, ref_delay, fb_delay}, {26'h0, d[5:0]});
    for (k = 0; k < 4; k++) begin
      acc(1, pvsc_pkg::IDX_SYNC_DELAY, {k[1:0], 6'h00}, 0);
      commit();
      sync_pin <= 1;
      repeat (8) @(posedge mclk);
      check({31'h0, counter_rst}, {31'h0, k == 1 || k == 2});
      sync_pin <= 0;
      repeat (8) @(posedge mclk);
      check({31'h0, counter_rst}, 32'h0);
    end
    // Oscillator divider is taken as running throughout
    for (k = 0; k < 4; k++) begin
      acc(1, pvsc_pkg::IDX_CAL_CTRL, {5'h0, k[1:0], 1'b0}, 0);
      commit();
      acc(1, pvsc_pkg::IDX_CAL_CTRL, {5'h0, k[1:0], 1'b1}, 0);
      commit();
      acc(0, pvsc_pkg::IDX_STATUS, 0, 8'h01);
      for (n = 0; n < 5000 && cal_busy === 1'b1; n++) @(posedge mclk);
      if (n == 5000) bad_count++;
      // Busy length measured from the rise; first tick lands within one period
      e = 256 << k;
      check({31'h0, busy_len >= e - 64 && busy_len <= e}, 32'h1);
      commit();
      check({31'h0, cal_busy}, 32'h0);
    end
    for (k = 0; k < 16; k++) begin
      status_src <= $random(seed);
      repeat (2) @(posedge mclk);
      check({31'h0, status_pin}, {31'h0, status_src});
    end
    acc(1, pvsc_pkg::IDX_STAT_DIV, 8'h80, 0);
    commit();
    n = 0;
    for (k = 0; k < 64; k++) begin
      status_src <= k[1];
      p = status_pin;
      @(posedge mclk);
      if (status_pin !== p) n++;
    end
    check({31'h0, n == 7 || n == 8}, 32'h1);
    print_verdict();
  end
endmodule
